// >>> common/spic_map.vh
`ifndef SPIC_MAP_VH
`define SPIC_MAP_VH

// register offsets on the serial control port (15-bit address space)
`define SPIC_ADDR_W          15
`define SPIC_OFS_CFG_A       15'h0000
`define SPIC_OFS_CFG_B       15'h0001
`define SPIC_OFS_DEV         15'h0002

// serial_port_config_a field positions
`define SPIC_A_MAIN_RST      0
`define SPIC_A_LOW_FIRST     1
`define SPIC_A_ADDR_UP       2
`define SPIC_A_FOUR_WIRE     3

// serial_port_config_b field positions
`define SPIC_B_RST_ZERO      1
`define SPIC_B_RST_ONE       2
`define SPIC_B_STALL         6
`define SPIC_B_ONE_INSTR     7

// reset values
`define SPIC_CFG_A_RST       3'h0
`define SPIC_CFG_B_RST       5'h00
`define SPIC_DEV_RST         8'h00

// instruction word: read/write flag then 15 address bits
`define SPIC_INSTR_BITS      4'hF
`define SPIC_BYTE_LAST       3'h7

// self-clearing reset pulse length
`define SPIC_CLK_PERIOD_NS   50
`define SPIC_RST_PULSE_NS    400
`define SPIC_RST_CYCLES      ((`SPIC_RST_PULSE_NS + `SPIC_CLK_PERIOD_NS - 1) \
                              / `SPIC_CLK_PERIOD_NS)

`endif

// >>> sim/spic_cfg_asserts.sv
`timescale 1ns/1ps
// ****
// pin and reset checks
// ****
module spic_cfg_asserts (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic       sdio_oe,
   input wire logic       sdo_oe,
   input wire logic       main_soft_reset,
   input wire logic       reset_one_pulse,
   input wire logic       reset_zero_pulse,
   input wire logic       four_wire_enable,
   input wire logic       bit_order_low_first,
   input wire logic       addr_direction_up,
   input wire logic [3:0] device_state_field
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   AST_OE_FOUR:
      assert property (four_wire_enable |-> !sdio_oe) else $error("sdio oe");
   AST_OE_THREE:
      assert property (!four_wire_enable |-> !sdo_oe) else $error("sdo oe");
   AST_OE_END:
      assert property ($rose(cs_n) |-> ##5 !(sdio_oe || sdo_oe))
      else $error("oe after deselect");
   AST_MAIN_LEN:
      assert property ($rose(main_soft_reset) |-> main_soft_reset[*8]
         ##1 !main_soft_reset) else $error("main pulse length");
   AST_ONE_LEN:
      assert property ($rose(reset_one_pulse) |-> reset_one_pulse[*8]
         ##1 !reset_one_pulse) else $error("reset one length");
   AST_ZERO_LEN:
      assert property ($rose(reset_zero_pulse) |-> reset_zero_pulse[*8]
         ##1 !reset_zero_pulse) else $error("reset zero length");
   AST_MAIN_CLR:
      assert property ($fell(main_soft_reset) |-> ##2 !(four_wire_enable
         || bit_order_low_first || addr_direction_up
         || device_state_field != 4'h0)) else $error("main clear");
   AST_CFG_HOLD:
      assert property (cs_n && $past(cs_n) && !main_soft_reset
         && !$past(main_soft_reset) && !$past(main_soft_reset, 2)
         && !$past(main_soft_reset, 3) |-> $stable({four_wire_enable,
         bit_order_low_first, addr_direction_up, device_state_field}))
      else $error("config moved while idle");
   // main scenarios reached
   cover property ($rose(main_soft_reset));
   cover property ($rose(sdo_oe));
   cover property ($rose(sdio_oe));
endmodule // spic_cfg_asserts
bind spic_config_port spic_cfg_asserts spic_cfg_asserts_i (.clock, .reset,
   .cs_n, .sdio_oe, .sdo_oe, .main_soft_reset, .reset_one_pulse,
   .reset_zero_pulse, .four_wire_enable, .bit_order_low_first,
   .addr_direction_up, .device_state_field);

// >>> sim/spic_host.sv
`timescale 1ns/1ps
// ****
// serial host model
// ****
module spic_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   output logic      mosi_oe,
   input  wire logic miso
);
   logic [7:0] dat [0:3];
   // idle: deselected, link clock parked low
   initial begin
      sclk = 0;
      cs_n = 1;
      mosi = 0;
      mosi_oe = 1;
   end
   // one link period; read bit taken late in the high phase for margin
   task automatic bit_cyc(input logic b, output logic r);
      mosi = b;
      #200 sclk = 1;
      #190 r = miso;
      #10 sclk = 0;
   endtask
   // whole frame: instruction, then n bytes, then deselect
   task automatic xfer(input logic rd, input logic [14:0] a,
                       input logic lsb, input int n);
      logic [15:0] w;
      logic [7:0] b;
      logic r;
      int i;
      int j;
      w = {rd, a};
      if (lsb) w = {<<{w}};
      cs_n = 0;
      for (j = 15; j >= 0; j--) bit_cyc(w[j], r);
      mosi_oe = !rd; // line released while the device answers
      for (i = 0; i < n; i++) begin
         b = dat[i];
         if (lsb) b = {<<{dat[i]}};
         for (j = 7; j >= 0; j--) bit_cyc(b[j], b[j]);
         if (rd && lsb) dat[i] = {<<{b}};
         else if (rd) dat[i] = b;
      end
      #200 cs_n = 1;
      mosi_oe = 1;
      #400;
   endtask
endmodule // spic_host

// >>> sim/spic_tb.sv
`timescale 1ns/1ps
`include "spic_map.vh"
`define CHK(e, g, nm) begin check_count++; if ((g) !== (e)) begin \
   n_mismatch++; $display("FAIL %s exp %h got %h", nm, e, g); end end
// ****
// testbench
// ****
module testbench;
   logic       clock, reset, sclk, cs_n, mosi, mosi_oe, sdio_in, mfw;
   logic       sdio_out, sdio_oe, sdo, sdo_oe, main_soft_reset;
   logic       reset_one_pulse, reset_zero_pulse, four_wire_enable;
   logic       bit_order_low_first, addr_direction_up, select_stall_enable;
   logic       one_instruction_mode;
   logic [3:0] device_state_field;
   logic [1:0] customer_op_mode, system_op_mode;
   logic [7:0] mdl [0:2];
   logic [7:0] rnd, seed;
   int         n_mismatch, check_count, k;
   int         plen [0:2];
   wire [12:0] cfg = {four_wire_enable, addr_direction_up,
      bit_order_low_first, one_instruction_mode, select_stall_enable,
      device_state_field, customer_op_mode, system_op_mode};
   // released line shows the inverse of the last host bit
   assign sdio_in = sdio_oe ? sdio_out : (mosi_oe ? mosi : ~mosi);
   spic_config_port spic_config_port_i (.clock, .reset, .sclk, .cs_n,
      .sdio_in, .sdio_out, .sdio_oe, .sdo, .sdo_oe, .main_soft_reset,
      .reset_one_pulse, .reset_zero_pulse, .four_wire_enable,
      .bit_order_low_first, .addr_direction_up, .select_stall_enable,
      .one_instruction_mode, .device_state_field, .customer_op_mode,
      .system_op_mode);
   // a released sdo shows the inverse of its last bit
   spic_host spic_host_i (.sclk, .cs_n, .mosi, .mosi_oe,
      .miso(mfw ? (sdo_oe ? sdo : ~sdo) : sdio_in));
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   // high time of each self-clearing reset line
   always @(posedge clock) begin
      plen[0] <= plen[0] + main_soft_reset;
      plen[1] <= plen[1] + reset_one_pulse;
      plen[2] <= plen[2] + reset_zero_pulse;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic frame(input logic rd, input int a, input int n);
      mfw = mdl[0][3];
      @(posedge clock);
      #1 spic_host_i.xfer(rd, a[14:0], mdl[0][1], n);
   endtask
   task automatic wr(input int a, input int n);
      int i;
      frame(1'b0, a, n);
      for (i = 0; i < n; i++) begin
         rnd = spic_host_i.dat[i];
         if (a == 0 && rnd[0]) mdl = '{default: 8'h00};
         else if (a == 0) mdl[0] = {4'h0, rnd[3:1], 1'b0};
         else if (a == 1) mdl[1] = rnd & 8'hF8;
         else if (a == 2) mdl[2] = rnd;
         a = (mdl[0][2] ? a + 1 : a - 1) & 32'h7FFF;
      end
      `CHK({mdl[0][3:1], mdl[1][7:6], mdl[2]}, cfg, "cfg")
   endtask
   task automatic rdc(input int a, input int n);
      int i;
      frame(1'b1, a, n);
      for (i = 0; i < n; i++) begin
         rnd = (a > 2) ? 8'h00 : mdl[a];
         if (a == 0) rnd[7:4] = {<<{mdl[0][3:0]}};
         `CHK(rnd, spic_host_i.dat[i], "read")
         a = (mdl[0][2] ? a + 1 : a - 1) & 32'h7FFF;
      end
   endtask
   task automatic pulses(input int m, input int o, input int z);
      `CHK(m * `SPIC_RST_CYCLES, plen[0], "main pulse")
      `CHK(o * `SPIC_RST_CYCLES, plen[1], "one pulse")
      `CHK(z * `SPIC_RST_CYCLES, plen[2], "zero pulse")
      plen = '{default: 0};
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      reset = 1;
      mfw = 0;
      plen = '{default: 0};
      mdl = '{default: 8'h00};
      seed = lfsr(8'h18);
      repeat (12) @(posedge clock);
      #1 reset = 0;
      rdc(0, 3);
      spic_host_i.dat = '{8'h04, 8'h00, 8'h00, 8'h00};
      wr(0, 1);
      rdc(0, 1);
      spic_host_i.dat = '{8'h7E, seed, 8'h00, 8'h00};
      wr(1, 2);
      pulses(0, 1, 1);
      spic_host_i.dat[0] = 8'h00;
      wr(0, 1);
      rdc(2, 3);
      spic_host_i.dat[0] = 8'h0A;
      wr(0, 1);
      rdc(0, 1);
      for (k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         spic_host_i.dat[0] = seed;
         wr(2, 1);
         rdc(2, 1);
      end
      spic_host_i.dat[0] = 8'hFF;
      wr(3, 1);
      rdc(3, 1);
      spic_host_i.dat[0] = 8'h80;
      wr(1, 1);
      spic_host_i.dat[0] = 8'h0B;
      wr(0, 1);
      pulses(1, 0, 0);
      rdc(1, 2);
      test_done;
   end
   // hang guard
   initial begin
      #2000000;
      n_mismatch++;
      test_done;
   end
endmodule // testbench

// >>> src/spic_config_port.v
`timescale 1ns/1ps
`include "spic_map.vh"

module spic_config_port (
   input  wire       clock,
   input  wire       reset,
   input  wire       sclk,
   input  wire       cs_n,
   input  wire       sdio_in,
   output reg        sdio_out,
   output reg        sdio_oe,
   output reg        sdo,
   output reg        sdo_oe,
   output wire       main_soft_reset,
   output wire       reset_one_pulse,
   output wire       reset_zero_pulse,
   output wire       four_wire_enable,
   output wire       bit_order_low_first,
   output wire       addr_direction_up,
   output wire       select_stall_enable,
   output wire       one_instruction_mode,
   output wire [3:0] device_state_field,
   output wire [1:0] customer_op_mode,
   output wire [1:0] system_op_mode
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_INSTR = 4'b0010;
   localparam [3:0] ST_DATA  = 4'b0100;
   localparam [3:0] ST_HOLD  = 4'b1000;
   localparam integer RST_CYCLES = `SPIC_RST_CYCLES;
   localparam [3:0] RST_LEN  = RST_CYCLES[3:0];

   reg  [2:0]                cfg_a_q;    // bits 3..1 of config a
   reg  [4:0]                cfg_b_q;    // bits 7..3 of config b
   reg  [7:0]                dev_q;
   reg  [3:0]                cnt_main_q;
   reg  [3:0]                cnt_one_q;
   reg  [3:0]                cnt_zero_q;
   reg  [2:0]                sclk_s_q;
   reg  [1:0]                cs_s_q;
   reg  [1:0]                din_s_q;
   reg  [3:0]                state_q;
   reg  [3:0]                cnt_q;
   reg  [15:0]               sh_q;
   reg  [`SPIC_ADDR_W-1:0]   addr_q;
   reg                       rd_q;
   reg                       lsb_q;      // bit order held for a frame
   reg  [7:0]                rd_byte_q;

   wire                      sclk_rise;
   wire                      sclk_fall;
   wire                      cs_act;
   wire [15:0]               sh_next;
   wire [7:0]                byte_in;
   wire [`SPIC_ADDR_W-1:0]   addr_step;

   // ****************************************************************
   // helper functions
   // ****************************************************************
   // one serial bit into the shift word, from the top when low first
   function [15:0] shift_in;
      input [15:0] v;
      input        b;
      input        low_first;
      begin
         shift_in = low_first ? {b, v[15:1]} : {v[14:0], b};
      end
   endfunction

   // read bit for the current count in the frame's bit order
   function pick_bit;
      input [7:0] v;
      input [2:0] n;
      input       low_first;
      begin
         pick_bit = low_first ? v[n] : v[3'h7 - n];
      end
   endfunction

   // register read mux; unmapped addresses read as zero
   function [7:0] reg_read;
      input [`SPIC_ADDR_W-1:0] a;
      reg   [3:0]              lo;
      begin
         lo = {cfg_a_q, (cnt_main_q != 4'h0)};
         case (a)
            `SPIC_OFS_CFG_A:
               reg_read = {lo[0], lo[1], lo[2], lo[3], lo};
            `SPIC_OFS_CFG_B: reg_read = {cfg_b_q, (cnt_one_q != 4'h0),
                                         (cnt_zero_q != 4'h0), 1'b0};
            `SPIC_OFS_DEV:   reg_read = dev_q;
            default:         reg_read = 8'h00;
         endcase
      end
   endfunction

   // ****************************************************************
   // pin synchronisers and edge detection
   // ****************************************************************
   // two flops before use; the third sclk flop only serves edge finding
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sclk_s_q <= 3'h0;
         cs_s_q   <= 2'h3;
         din_s_q  <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], sclk};
         cs_s_q   <= {cs_s_q[0], cs_n};
         din_s_q  <= {din_s_q[0], sdio_in};
      end
   end

   assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
   assign cs_act    = ~cs_s_q[1];
   assign sh_next   = shift_in(sh_q, din_s_q[1], lsb_q);
   assign byte_in   = lsb_q ? sh_next[15:8] : sh_next[7:0];
   // step direction taken live from config a
   assign addr_step = cfg_a_q[`SPIC_A_ADDR_UP - 1] ?
                      addr_q + 15'h0001 : addr_q - 15'h0001;

   // ****************************************************************
   // serial engine and register file
   // ****************************************************************
   // writes land when the eighth bit of a byte is taken
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 4'h0;
         sh_q       <= 16'h0000;
         addr_q     <= 15'h0000;
         rd_q       <= 1'b0;
         lsb_q      <= 1'b0;
         rd_byte_q  <= 8'h00;
         cfg_a_q    <= `SPIC_CFG_A_RST;
         cfg_b_q    <= `SPIC_CFG_B_RST;
         dev_q      <= `SPIC_DEV_RST;
         cnt_main_q <= 4'h0;
         cnt_one_q  <= 4'h0;
         cnt_zero_q <= 4'h0;
      end else begin
         // reset pulse counters run down on their own
         if (cnt_one_q != 4'h0)
            cnt_one_q <= cnt_one_q - 4'h1;
         if (cnt_zero_q != 4'h0)
            cnt_zero_q <= cnt_zero_q - 4'h1;
         if (cnt_main_q != 4'h0)
            cnt_main_q <= cnt_main_q - 4'h1;
         if (!cs_act) begin
            state_q <= ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  // bit order is frozen per frame; a change mid-word would
                  // scramble the byte being shifted
                  lsb_q   <= cfg_a_q[`SPIC_A_LOW_FIRST - 1];
                  cnt_q   <= 4'h0;
                  state_q <= ST_INSTR;
               end
               ST_INSTR: begin
                  if (sclk_rise) begin
                     sh_q  <= sh_next;
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == `SPIC_INSTR_BITS) begin
                        cnt_q     <= 4'h0;
                        rd_q      <= sh_next[15];
                        addr_q    <= sh_next[14:0];
                        rd_byte_q <= reg_read(sh_next[14:0]);
                        state_q   <= ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_rise) begin
                     sh_q  <= sh_next;
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q[2:0] == `SPIC_BYTE_LAST) begin
                        cnt_q     <= 4'h0;
                        addr_q    <= addr_step;
                        rd_byte_q <= reg_read(addr_step);
                        if (cfg_b_q[`SPIC_B_ONE_INSTR - 3])
                           state_q <= ST_HOLD;
                        if (!rd_q) begin
                           case (addr_q)
                              `SPIC_OFS_CFG_A: begin
                                 cfg_a_q <= byte_in[3:1];
                                 if (byte_in[`SPIC_A_MAIN_RST])
                                    cnt_main_q <= RST_LEN;
                              end
                              `SPIC_OFS_CFG_B: begin
                                 cfg_b_q <= byte_in[7:3];
                                 if (byte_in[`SPIC_B_RST_ONE])
                                    cnt_one_q <= RST_LEN;
                                 if (byte_in[`SPIC_B_RST_ZERO])
                                    cnt_zero_q <= RST_LEN;
                              end
                              `SPIC_OFS_DEV: dev_q <= byte_in;
                              default: dev_q <= dev_q;
                           endcase
                        end
                     end
                  end
               end
               ST_HOLD: state_q <= ST_HOLD;
               default: state_q <= ST_IDLE;
            endcase
         end
         // the main reset returns the configuration to defaults as it ends
         if (cnt_main_q == 4'h1) begin
            cfg_a_q <= `SPIC_CFG_A_RST;
            cfg_b_q <= `SPIC_CFG_B_RST;
            dev_q   <= `SPIC_DEV_RST;
         end
      end
   end

   // ****************************************************************
   // read data driver
   // ****************************************************************
   // new bit after each falling sclk edge, held through the rising edge
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
         sdo      <= 1'b0;
         sdo_oe   <= 1'b0;
      end else begin
         if (cs_act && state_q == ST_DATA && rd_q) begin
            if (sclk_fall) begin
               sdio_out <= pick_bit(rd_byte_q, cnt_q[2:0], lsb_q);
               sdo      <= pick_bit(rd_byte_q, cnt_q[2:0], lsb_q);
            end
            sdo_oe  <= cfg_a_q[`SPIC_A_FOUR_WIRE - 1];
            sdio_oe <= ~cfg_a_q[`SPIC_A_FOUR_WIRE - 1];
         end else begin
            sdio_oe <= 1'b0;
            sdo_oe  <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // configuration outputs
   // ****************************************************************
   assign main_soft_reset      = (cnt_main_q != 4'h0);
   assign reset_one_pulse      = (cnt_one_q != 4'h0);
   assign reset_zero_pulse     = (cnt_zero_q != 4'h0);
   assign four_wire_enable     = cfg_a_q[`SPIC_A_FOUR_WIRE - 1];
   assign bit_order_low_first  = cfg_a_q[`SPIC_A_LOW_FIRST - 1];
   assign addr_direction_up    = cfg_a_q[`SPIC_A_ADDR_UP - 1];
   assign select_stall_enable  = cfg_b_q[`SPIC_B_STALL - 3];
   assign one_instruction_mode = cfg_b_q[`SPIC_B_ONE_INSTR - 3];
   assign device_state_field   = dev_q[7:4];
   assign customer_op_mode     = dev_q[3:2];
   assign system_op_mode       = dev_q[1:0];

endmodule // spic_config_port
